// >>> design/scc_pkg.sv
package scc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] NS_CTRL_ADDR    = 12'h2a2;
  localparam logic [11:0] CAL_EN_ADDR     = 12'h2b0;
  localparam logic [11:0] CAL_CFG_ADDR    = 12'h2b1;
  localparam logic [7:0]  NS_CTRL_RST     = 8'h00;
  localparam logic [7:0]  CAL_EN_RST      = 8'h00;
  localparam logic [7:0]  CAL_CFG_RST     = 8'h05;
  localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          CAL_EN_BIT      = 0;
  localparam int          DIG_RAIL_BIT    = 5;
  localparam int          SEC_RAIL_BIT    = 4;
  localparam int          AVG_LSB         = 2;
  localparam int          AVG_MSB         = 3;

  // ****************************************************************
  // Delay and averaging
  // ****************************************************************
  localparam int          DELAY_W         = 17;
  localparam int          CNT_W           = 9;
  localparam int          SUM_W           = 25;
  localparam logic [16:0] DELAY_RST       = 17'h00000;

  // Engine states, Gray along idle, run, done
  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_RUN  = 2'b01,
    SCC_DONE = 2'b11
  } scc_state_t;

  // Averaging code to log2 of the number of measurements (4,16,64,256)
  function automatic logic [3:0] scc_avg_shift(input logic [1:0] sel);
    scc_avg_shift = 4'h2 + {1'b0, sel, 1'b0};
  endfunction

endpackage

// >>> design/scc_cal_engine.sv
`timescale 1ns/100ps
module scc_cal_engine
  import scc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  // Control
  input  wire logic                 start,
  input  wire logic                 abort,
  input  wire logic [1:0]           avg_sel,
  // Measurements
  input  wire logic                 meas_valid,
  input  wire logic [DELAY_W-1:0]   meas_delay,
  // Result
  output logic                      busy,
  output logic                      done,
  output logic [DELAY_W-1:0]        result
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  scc_state_t           state_ff;
  logic [CNT_W-1:0]     meas_cnt_ff;
  logic [SUM_W-1:0]     sum_ff;
  logic [3:0]           shift_ff;
  logic [CNT_W-1:0]     target;
  logic                 last_meas;

  // Averaging size is latched at start so a late config write cannot skew the sum
  assign target    = CNT_W'(9'h001 << shift_ff);
  assign last_meas = meas_valid && (meas_cnt_ff == target - 9'h001);

  // State and counters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff    <= SCC_IDLE;
      meas_cnt_ff <= 9'h000;
      sum_ff      <= 25'h0000000;
      shift_ff    <= 4'h2;
    end else if (ce) begin
      if (abort) begin
        state_ff <= SCC_IDLE;
      end else begin
        case (state_ff)
          SCC_IDLE, SCC_DONE: begin
            if (start) begin
              state_ff    <= SCC_RUN;
              meas_cnt_ff <= 9'h000;
              sum_ff      <= 25'h0000000;
              shift_ff    <= scc_avg_shift(avg_sel);
            end
          end
          SCC_RUN: begin
            if (meas_valid) begin
              sum_ff      <= sum_ff + SUM_W'(meas_delay);
              meas_cnt_ff <= meas_cnt_ff + 9'h001;
            end
            if (last_meas) begin
              state_ff <= SCC_DONE;
            end
          end
          default: state_ff <= SCC_IDLE;
        endcase
      end
    end
  end

  // Averaged delay, kept until the next sequence finishes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result <= DELAY_RST;
    end else if (ce && state_ff == SCC_RUN && last_meas && !abort) begin
      result <= DELAY_W'((sum_ff + SUM_W'(meas_delay)) >> shift_ff);
    end
  end

  assign busy = (state_ff == SCC_RUN);
  assign done = (state_ff == SCC_DONE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  avg_count_end_a: assert property (@(posedge clk) disable iff (reset)
    ce && !abort && state_ff == SCC_RUN && last_meas |=> done && meas_cnt_ff == target)
    else $error("Averaging did not end after the selected count");

  avg_shift_load_a: assert property (@(posedge clk) disable iff (reset)
    ce && !abort && !busy && start |=> busy && shift_ff == 4'h2 + 4'(2 * $past(avg_sel)))
    else $error("Averaging size not taken at start");

  sum_sequence_c: cover property (@(posedge clk) disable iff (reset)
    busy ##[1:300] done);

endmodule

// >>> design/scc_top.sv
// What this block does
// - Enable low: aperture delay output follows the manual delay value.
// - Enable high: delay comes from automatic calibration, manual value ignored.
// - Only a 0-to-1 change of the enable starts calibration.
// - Bit 5 of noise control enables digital core supply suppression.
// - Bit 4 of noise control enables second core supply suppression.
// - Configuration resets to 0x05; upper four bits reserved, reset zero.
// - Bits 3:2 pick 4, 16, 64 or 256 averaged measurements.
`timescale 1ns/100ps
module scc_top
  import scc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  // Register access
  input  wire logic                 WR_EN,
  input  wire logic                 RD_EN,
  input  wire logic [ADDR_W-1:0]    ADDR,
  input  wire logic [DATA_W-1:0]    WDATA,
  output logic      [DATA_W-1:0]    RDATA,
  // Delay control
  input  wire logic [DELAY_W-1:0]   MANUAL_DELAY,
  input  wire logic                 MEAS_VALID,
  input  wire logic [DELAY_W-1:0]   MEAS_DELAY,
  output logic      [DELAY_W-1:0]   APERTURE_DELAY,
  // Status and supply controls
  output logic                      CAL_BUSY,
  output logic                      CAL_DONE,
  output logic                      DIGITAL_RAIL_NOISE_SUPPRESS_EN,
  output logic                      SECOND_RAIL_NOISE_SUPPRESS_EN
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]           ns_ctrl_ff;
  logic [7:0]           cal_en_ff;
  logic [7:0]           cal_cfg_ff;
  logic                 wr_ns;
  logic                 wr_en_reg;
  logic                 wr_cfg;
  logic                 cal_start;
  logic                 cal_abort;
  logic                 eng_busy;
  logic                 eng_done;
  logic [DELAY_W-1:0]   eng_result;
  logic [DATA_W-1:0]    nxt_rdata;

  assign wr_ns     = WR_EN && (ADDR == NS_CTRL_ADDR);
  assign wr_en_reg = WR_EN && (ADDR == CAL_EN_ADDR);
  assign wr_cfg    = WR_EN && (ADDR == CAL_CFG_ADDR);

  // Start only on a rising enable, so rewriting a 1 never restarts
  assign cal_start = wr_en_reg && WDATA[CAL_EN_BIT] && !cal_en_ff[CAL_EN_BIT];
  assign cal_abort = wr_en_reg && !WDATA[CAL_EN_BIT];

  // Noise suppression control, all bits stored
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ns_ctrl_ff <= NS_CTRL_RST;
    end else if (CE && wr_ns) begin
      ns_ctrl_ff <= WDATA;
    end
  end

  // Calibration enable; bits 7:1 are plain storage
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cal_en_ff <= CAL_EN_RST;
    end else if (CE && wr_en_reg) begin
      cal_en_ff <= WDATA;
    end
  end

  // Calibration configuration; host must set it before enabling
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cal_cfg_ff <= CAL_CFG_RST;
    end else if (CE && wr_cfg) begin
      cal_cfg_ff <= WDATA;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read mux; unmapped addresses answer zero
  always_comb begin
    case (ADDR)
      NS_CTRL_ADDR: nxt_rdata = ns_ctrl_ff;
      CAL_EN_ADDR:  nxt_rdata = cal_en_ff;
      CAL_CFG_ADDR: nxt_rdata = cal_cfg_ff;
      default:      nxt_rdata = UNMAPPED_RDATA;
    endcase
  end

  // Read data registered, held until the next read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (CE && RD_EN) begin
      RDATA <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Calibration engine
  // ****************************************************************
  scc_cal_engine i_scc_cal_engine (
    .clk        (CLK),
    .reset      (RESET),
    .ce         (CE),
    .start      (cal_start),
    .abort      (cal_abort),
    .avg_sel    (cal_cfg_ff[AVG_MSB:AVG_LSB]),
    .meas_valid (MEAS_VALID),
    .meas_delay (MEAS_DELAY),
    .busy       (eng_busy),
    .done       (eng_done),
    .result     (eng_result)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Delay source: manual value when disabled, calibrated value otherwise
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      APERTURE_DELAY <= DELAY_RST;
    end else if (CE) begin
      if (cal_en_ff[CAL_EN_BIT]) begin
        APERTURE_DELAY <= eng_result;
      end else begin
        APERTURE_DELAY <= MANUAL_DELAY;
      end
    end
  end

  // Status mirrors the engine one cycle late to keep outputs on flops
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CAL_BUSY <= 1'b0;
      CAL_DONE <= 1'b0;
    end else if (CE) begin
      CAL_BUSY <= eng_busy;
      CAL_DONE <= eng_done;
    end
  end

  // Supply noise suppression enables, costing a little power when set
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      DIGITAL_RAIL_NOISE_SUPPRESS_EN <= NS_CTRL_RST[DIG_RAIL_BIT];
      SECOND_RAIL_NOISE_SUPPRESS_EN  <= NS_CTRL_RST[SEC_RAIL_BIT];
    end else if (CE && wr_ns) begin
      DIGITAL_RAIL_NOISE_SUPPRESS_EN <= WDATA[DIG_RAIL_BIT];
      SECOND_RAIL_NOISE_SUPPRESS_EN  <= WDATA[SEC_RAIL_BIT];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  manual_delay_a: assert property (
    CE && !cal_en_ff[CAL_EN_BIT] |=> APERTURE_DELAY == $past(MANUAL_DELAY))
    else $error("Aperture delay does not follow manual value");

  auto_delay_a: assert property (
    CE && cal_en_ff[CAL_EN_BIT] |=> APERTURE_DELAY == $past(eng_result))
    else $error("Aperture delay not taken from calibration");

  start_edge_a: assert property (
    CE && wr_en_reg && WDATA[CAL_EN_BIT] && !cal_en_ff[CAL_EN_BIT] |=> ##1 CAL_BUSY)
    else $error("Calibration did not start on rising enable");

  no_restart_a: assert property (
    CE && wr_en_reg && WDATA[CAL_EN_BIT] && eng_done && cal_en_ff[CAL_EN_BIT]
      |=> eng_done)
    else $error("Rewriting enable restarted calibration");

  dig_rail_a: assert property (
    CE && wr_ns |=> DIGITAL_RAIL_NOISE_SUPPRESS_EN == $past(WDATA[DIG_RAIL_BIT]))
    else $error("Digital rail enable not updated");

  sec_rail_a: assert property (
    CE && wr_ns |=> SECOND_RAIL_NOISE_SUPPRESS_EN == $past(WDATA[SEC_RAIL_BIT]))
    else $error("Second rail enable not updated");

  cfg_reset_a: assert property (
    $fell(RESET) |-> cal_cfg_ff == CAL_CFG_RST && RDATA == 8'h00)
    else $error("Configuration reset value wrong");

  // Register accesses leave one idle cycle between write and read-back
  reserved_rw_a: assert property (
    CE && wr_cfg && !RD_EN ##1 !wr_cfg ##1 CE && RD_EN && ADDR == CAL_CFG_ADDR && !WR_EN
      |=> RDATA[7:4] == $past(WDATA[7:4], 3))
    else $error("Reserved bits not read back");

  ns_store_a: assert property (
    CE && wr_ns |=> ns_ctrl_ff == $past(WDATA))
    else $error("Noise control bits not stored");

  en_store_a: assert property (
    CE && wr_en_reg |=> cal_en_ff == $past(WDATA))
    else $error("Enable register bits not stored");

  // Clearing the enable must stop the engine, whatever state it is in
  abort_idle_a: assert property (
    CE && cal_abort |=> !eng_busy && !eng_done)
    else $error("Clearing the enable did not stop calibration");

  start_c:  cover property (CE && cal_start);
  done_c:   cover property (CAL_BUSY ##[1:300] CAL_DONE);
  manual_c: cover property (CE && !cal_en_ff[CAL_EN_BIT] && MANUAL_DELAY != 17'h00000);
  read_c:   cover property (CE && RD_EN && ADDR == CAL_CFG_ADDR);

endmodule

// >>> tb/scc_top_test.sv
`timescale 1ns/100ps
module scc_top_test;
  import scc_pkg::*;

  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic                 clk;
  logic                 reset;
  logic                 ce;
  logic                 wr_en;
  logic                 rd_en;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rdata;
  logic [DELAY_W-1:0]   manual_delay;
  logic                 meas_valid;
  logic [DELAY_W-1:0]   meas_delay;
  logic [DELAY_W-1:0]   aperture_delay;
  logic                 cal_busy;
  logic                 cal_done;
  logic                 dig_rail_en;
  logic                 sec_rail_en;
  int                   error_cnt;
  int                   samples_checked;
  int                   cycles = 0;
  // Rail patterns, one with every reserved bit set and both rails off
  logic [7:0]           ns_pat [4] = '{8'h20, 8'h10, 8'hcf, 8'h30};

  // Device under test
  scc_top i_scc_top (
    .CLK                            (clk),
    .RESET                          (reset),
    .CE                             (ce),
    .WR_EN                          (wr_en),
    .RD_EN                          (rd_en),
    .ADDR                           (addr),
    .WDATA                          (wdata),
    .RDATA                          (rdata),
    .MANUAL_DELAY                   (manual_delay),
    .MEAS_VALID                     (meas_valid),
    .MEAS_DELAY                     (meas_delay),
    .APERTURE_DELAY                 (aperture_delay),
    .CAL_BUSY                       (cal_busy),
    .CAL_DONE                       (cal_done),
    .DIGITAL_RAIL_NOISE_SUPPRESS_EN (dig_rail_en),
    .SECOND_RAIL_NOISE_SUPPRESS_EN  (sec_rail_en)
  );

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Longest run is about 500 cycles, so ten times that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic check(input logic [DELAY_W-1:0] seen, input logic [DELAY_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // Strobe is raised after one edge and taken at the next
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data is registered at the taking edge, looked at half a cycle later
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(17'(rdata), 17'(exp));
  endtask

  // Full calibration at one averaging code, then a repeated set and an abort
  task automatic cal_run(input logic [1:0] code);
    int          n;
    int          sum;
    logic [16:0] v;
    n   = 4 << (2 * code);
    sum = 0;
    wr(CAL_CFG_ADDR, {4'ha, code, 2'b01});
    rd_chk(CAL_CFG_ADDR, {4'ha, code, 2'b01});
    @(posedge clk);
    manual_delay <= 17'h0aaaa;
    // No core calibration runs in this bench, so enabling is always allowed
    wr(CAL_EN_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(17'(cal_busy), 17'h1);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      v = 17'h1f000 + 17'((i * 37) % 101);
      meas_valid <= 1'b1;
      meas_delay <= v;
      sum += int'(v);
    end
    @(posedge clk);
    meas_valid <= 1'b0;
    meas_delay <= 17'h00000;
    // Last measurement taken at this edge; done shows one edge later
    @(negedge clk);
    check(17'(cal_done), 17'h0);
    @(negedge clk);
    check(17'(cal_done), 17'h1);
    check(aperture_delay, 17'(sum / n));
    // A second set while already high must not restart the engine
    wr(CAL_EN_ADDR, 8'h01);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(17'(cal_busy), 17'h0);
    check(17'(cal_done), 17'h1);
    check(aperture_delay, 17'(sum / n));
    // Clearing the enable hands the delay back to the manual value
    wr(CAL_EN_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(aperture_delay, 17'h0aaaa);
    $display("test calibration code %0d done", code);
  endtask

  // Single place where the run ends
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    reset           = 1'b1;
    ce              = 1'b1;
    wr_en           = 1'b0;
    rd_en           = 1'b0;
    addr            = 12'h000;
    wdata           = 8'h00;
    manual_delay    = 17'h00123;
    meas_valid      = 1'b0;
    meas_delay      = 17'h00000;
    error_cnt       = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Reset values and the manual path
    rd_chk(NS_CTRL_ADDR, NS_CTRL_RST);
    rd_chk(CAL_EN_ADDR, CAL_EN_RST);
    rd_chk(CAL_CFG_ADDR, CAL_CFG_RST);
    check(aperture_delay, 17'h00123);
    $display("test reset_values done");
    // Rail enables follow their own bits only
    foreach (ns_pat[k]) begin
      wr(NS_CTRL_ADDR, ns_pat[k]);
      rd_chk(NS_CTRL_ADDR, ns_pat[k]);
      check(17'(dig_rail_en), 17'(ns_pat[k][5]));
      check(17'(sec_rail_en), 17'(ns_pat[k][4]));
    end
    $display("test noise_control done");
    // Unmapped place reads zero and must not alias onto the map
    wr(12'h2b2, 8'h5a);
    rd_chk(12'h2b2, UNMAPPED_RDATA);
    rd_chk(CAL_CFG_ADDR, CAL_CFG_RST);
    // A strobe with the clock enable low is ignored
    @(posedge clk);
    ce <= 1'b0;
    wr(CAL_CFG_ADDR, 8'hff);
    ce <= 1'b1;
    rd_chk(CAL_CFG_ADDR, CAL_CFG_RST);
    $display("test refused_access done");
    // Manual delay tracked while calibration is off
    @(posedge clk);
    manual_delay <= 17'h1abcd;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(aperture_delay, 17'h1abcd);
    $display("test manual_delay done");
    for (int c = 0; c < 4; c++) begin
      cal_run(2'(c));
    end
    summarize();
  end

endmodule
